// ---- rtl/csr_status_regs.vh ----
`ifndef CSR_STATUS_REGS_VH
`define CSR_STATUS_REGS_VH

// ----------------------------------------
// Group select
// ----------------------------------------
`define CSR_GRP_CAL        1'h0
`define CSR_GRP_HW         1'h1

// ----------------------------------------
// Register select within a group
// ----------------------------------------
`define CSR_REG_COND       3'h0
`define CSR_REG_RISE       3'h1
`define CSR_REG_FALL       3'h2
`define CSR_REG_EVENT      3'h3
`define CSR_REG_ENABLE     3'h4

// ----------------------------------------
// Widths, masks and reset values
// ----------------------------------------
`define CSR_WIDTH          16
`define CSR_ZERO           16'h0000
`define CSR_RISE_RESET     16'h7FFF
`define CSR_FALL_RESET     16'h0000
`define CSR_CAL_USED_MASK  16'h001F
`define CSR_HW_USED_MASK   16'h0FFF

// ----------------------------------------
// Calibration condition bits
// ----------------------------------------
`define CSR_CAL_TXPWR_ZERO 4
`define CSR_CAL_VOLTMETER  3
`define CSR_CAL_COUNTER    2
`define CSR_CAL_SAMPLER    1
`define CSR_CAL_SPECTRUM   0

// ----------------------------------------
// Hardware conflict condition bits
// ----------------------------------------
`define CSR_HW_ACP_RBW     11
`define CSR_HW_ACP_WIDE    10
`define CSR_HW_NOTCH       9
`define CSR_HW_AUDIO_TWO   8
`define CSR_HW_FM_DEV      7
`define CSR_HW_AM_FM       6
`define CSR_HW_AUDIO_RANGE 5
`define CSR_HW_RF_RANGE    4
`define CSR_HW_RF_TUNE     3
`define CSR_HW_OFFSET      2
`define CSR_HW_GEN_AMPL    1
`define CSR_HW_REF_LEVEL   0
`define CSR_MSB            15

`endif

// ---- rtl/csr_status.v ----
// Notes on behaviour
// - Each group: 16-bit condition, rise/fall filters, event, enable, summary.
// - Condition bit 15 always reads zero in both groups.
// - Calibration bit 4 set while transmit power auto-zero failed.
// - Calibration bit 3 set when voltmeter self-calibration failed.
// - Calibration bit 2 set when counter self-calibration failed.
// - Calibration bit 1 set when sampler self-calibration failed.
// - Calibration bit 0 set when spectrum analyzer self-calibration failed.
// - Event register clears when read, and on clear-status command.
// - Enable has no clear; writing zero holds all enable bits zero.
// - Host reads and writes both transition filters of each group.
// - Condition register is read only and returns its current value.
// - Host reads enable register and loads it by writing a value.
// - Hardware bit 11: adjacent-channel-power bandwidth inconsistent with resolution bandwidth.
// - Hardware bit 10: adjacent-channel-power bandwidth or offset too wide.
// - Hardware bit 9: first audio source outside notch filter range.
// - Hardware bit 8: audio voltage exceeds second audio source capability.
// - Hardware bit 7: FM deviation too large for generator frequency.
// - AM and FM together refused; hardware bit 6 flags the request.
// - Hardware bits 5, 4, 3: audio range, RF range, RF tune errors.
// - Hardware bit 2: generator minus analyzer frequency differs from offset.
// - Hardware bit 1: generator amplitude too high; bit 0: reference level.
`timescale 1ns/1ps
`include "csr_status_regs.vh"

module csr_status (
    // Clock and reset
    input  wire        i_sys_clk,
    input  wire        i_rst,
    // Calibration failure inputs
    input  wire        i_txpwr_zero_fail,
    input  wire        i_voltmeter_cal_fail,
    input  wire        i_counter_cal_fail,
    input  wire        i_sampler_cal_fail,
    input  wire        i_spectrum_cal_fail,
    // Hardware conflict inputs
    input  wire        i_acp_rbw_mismatch,
    input  wire        i_acp_too_wide,
    input  wire        i_audio_source_one_notch,
    input  wire        i_audio_source_two_volt,
    input  wire        i_fm_dev_too_large,
    input  wire        i_am_request,
    input  wire        i_fm_request,
    input  wire        i_audio_range_err,
    input  wire        i_rf_range_err,
    input  wire        i_rf_tune_err,
    input  wire        i_offset_mismatch,
    input  wire        i_gen_ampl_high,
    input  wire        i_ref_level_bad,
    // Host status command port
    input  wire        i_cmd_valid,
    input  wire        i_cmd_write,
    input  wire        i_cmd_group,
    input  wire [2:0]  i_cmd_reg,
    input  wire [15:0] i_cmd_wdata,
    input  wire        i_clear_status,
    // Host answer
    output reg         o_rsp_valid,
    output reg  [15:0] o_rsp_data,
    // Modulation grant and summaries
    output reg         o_am_enable,
    output reg         o_fm_enable,
    output reg         o_cal_summary,
    output reg         o_hw_summary
);

    // ----------------------------------------
    // Condition sampling
    // ----------------------------------------
    wire [15:0] cal_raw;
    wire [15:0] hw_raw;
    wire        am_fm_clash;

    assign am_fm_clash = i_am_request & i_fm_request;

    assign cal_raw = {11'h000,
                      i_txpwr_zero_fail,
                      i_voltmeter_cal_fail,
                      i_counter_cal_fail,
                      i_sampler_cal_fail,
                      i_spectrum_cal_fail};

    assign hw_raw = {4'h0,
                     i_acp_rbw_mismatch,
                     i_acp_too_wide,
                     i_audio_source_one_notch,
                     i_audio_source_two_volt,
                     i_fm_dev_too_large,
                     am_fm_clash,
                     i_audio_range_err,
                     i_rf_range_err,
                     i_rf_tune_err,
                     i_offset_mismatch,
                     i_gen_ampl_high,
                     i_ref_level_bad};

    // ----------------------------------------
    // Group storage, index 0 calibration, 1 hardware
    // ----------------------------------------
    reg  [15:0] cond   [0:1];
    reg  [15:0] rise   [0:1];
    reg  [15:0] fall   [0:1];
    reg  [15:0] evt    [0:1];
    reg  [15:0] enable [0:1];
    wire [15:0] raw    [0:1];
    wire [15:0] used   [0:1];
    wire        summ   [0:1];

    assign raw[0]  = cal_raw;
    assign raw[1]  = hw_raw;
    assign used[0] = `CSR_CAL_USED_MASK;
    assign used[1] = `CSR_HW_USED_MASK;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : grp
            wire        sel;
            wire        wr;
            wire        rd_event;
            wire [15:0] cond_next;
            wire [15:0] edges;

            assign sel       = i_cmd_valid & (i_cmd_group == g);
            assign wr        = sel & i_cmd_write;
            assign rd_event  = sel & ~i_cmd_write & (i_cmd_reg == `CSR_REG_EVENT);
            // Bit 15 and unused bits are forced low at the source
            assign cond_next = raw[g] & used[g];
            // Filtered edges, seen in the same cycle the raw input changes
            assign edges = ((cond_next & ~cond[g]) & rise[g])
                         | ((~cond_next & cond[g]) & fall[g]);
            assign summ[g] = |(evt[g] & enable[g]);

            always @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    cond[g]   <= `CSR_ZERO;
                    rise[g]   <= `CSR_RISE_RESET;
                    fall[g]   <= `CSR_FALL_RESET;
                    evt[g]    <= `CSR_ZERO;
                    enable[g] <= `CSR_ZERO;
                end else begin
                    cond[g] <= cond_next;
                    // A new edge in the clearing cycle survives the clear
                    if (rd_event || i_clear_status) begin
                        evt[g] <= edges & used[g];
                    end else begin
                        evt[g] <= (evt[g] | edges) & used[g];
                    end
                    if (wr && i_cmd_reg == `CSR_REG_RISE) begin
                        rise[g] <= i_cmd_wdata;
                    end
                    if (wr && i_cmd_reg == `CSR_REG_FALL) begin
                        fall[g] <= i_cmd_wdata;
                    end
                    if (wr && i_cmd_reg == `CSR_REG_ENABLE) begin
                        enable[g] <= i_cmd_wdata;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    reg [15:0] rd_mux;
    reg        rd_grp;

    always @* begin
        rd_grp = i_cmd_group;
        case (i_cmd_reg)
            `CSR_REG_COND:   rd_mux = cond[rd_grp];
            `CSR_REG_RISE:   rd_mux = rise[rd_grp];
            `CSR_REG_FALL:   rd_mux = fall[rd_grp];
            `CSR_REG_EVENT:  rd_mux = evt[rd_grp];
            `CSR_REG_ENABLE: rd_mux = enable[rd_grp];
            default:         rd_mux = `CSR_ZERO;
        endcase
    end

    // ----------------------------------------
    // Answer and outputs
    // ----------------------------------------
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rsp_valid   <= 1'b0;
            o_rsp_data    <= `CSR_ZERO;
            o_am_enable   <= 1'b0;
            o_fm_enable   <= 1'b0;
            o_cal_summary <= 1'b0;
            o_hw_summary  <= 1'b0;
        end else begin
            // Writes to the condition register are silently dropped
            o_rsp_valid <= i_cmd_valid & ~i_cmd_write;
            if (i_cmd_valid && !i_cmd_write) begin
                o_rsp_data <= rd_mux;
            end
            // Neither modulation is granted while both are asked for
            o_am_enable   <= i_am_request & ~i_fm_request;
            o_fm_enable   <= i_fm_request & ~i_am_request;
            o_cal_summary <= summ[0];
            o_hw_summary  <= summ[1];
        end
    end

endmodule

// ---- test/csr_status_monitor.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Status port checker
// ----------------------------------------
module csr_status_monitor (
    input wire        i_sys_clk, i_rst, i_txpwr_zero_fail, i_voltmeter_cal_fail,
    input wire        i_counter_cal_fail, i_sampler_cal_fail, i_spectrum_cal_fail,
    input wire        i_am_request, i_fm_request, i_cmd_valid, i_cmd_write, i_cmd_group,
    input wire [2:0]  i_cmd_reg,
    input wire        i_clear_status, o_rsp_valid, o_am_enable, o_fm_enable, o_cal_summary,
    input wire [15:0] o_rsp_data
);
    wire [4:0] cal = {i_txpwr_zero_fail, i_voltmeter_cal_fail, i_counter_cal_fail,
                      i_sampler_cal_fail, i_spectrum_cal_fail};
    wire       rd  = i_cmd_valid & ~i_cmd_write;
    wire       cnd = rd & (i_cmd_reg == 3'h0);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // A quiet input gives no edge, so nothing can relatch behind a clear
    sequence s_cal_quiet;
        $stable(cal) [*3];
    endsequence
    a_read_answer: assert property (rd |=> o_rsp_valid) else $error("read unanswered");
    a_write_silent: assert property (i_cmd_valid && i_cmd_write |=> !o_rsp_valid)
        else $error("write answered");
    a_data_hold: assert property (!rd |=> $stable(o_rsp_data)) else $error("data moved");
    a_cond_msb: assert property (cnd |=> !o_rsp_data[15]) else $error("bit 15 set");
    a_cal_cond: assert property (cnd && !i_cmd_group && !$past(i_rst) && $stable(cal)
        |=> o_rsp_data == {11'h000, $past(cal)}) else $error("cal condition wrong");
    a_am_fm_block: assert property (i_am_request && i_fm_request
        |=> !o_am_enable && !o_fm_enable) else $error("both modulations granted");
    a_am_grant: assert property (i_am_request && !i_fm_request |=> o_am_enable && !o_fm_enable)
        else $error("am not granted");
    // The summary flop lags the event register by one edge
    a_clear_summary: assert property (s_cal_quiet ##0 i_clear_status ##1 $stable(cal)
        |=> !o_cal_summary) else $error("summary after clear");
endmodule

bind csr_status csr_status_monitor u_mon (.*);

// ---- test/csr_host.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Host issuing status commands
// ----------------------------------------
module csr_host (
    input  wire        i_sys_clk,
    input  wire        i_rsp_valid,
    input  wire [15:0] i_rsp_data,
    output reg         o_valid,
    output reg         o_write,
    output reg         o_group,
    output reg  [2:0]  o_reg,
    output reg  [15:0] o_wdata,
    output reg         o_clr
);
    initial {o_valid, o_write, o_group, o_reg, o_wdata, o_clr} = 23'h000000;
    // Enable has no clear command; the caller writes zero instead
    task cmd(input w, input g, input [2:0] r, input [15:0] d);
        begin
            @(negedge i_sys_clk);
            {o_valid, o_write, o_group, o_reg, o_wdata} = {1'b1, w, g, r, d};
            @(negedge i_sys_clk);
            o_valid = 1'b0;
            o_wdata = ~d; // Idle data moves so a stale word cannot pass for a write
        end
    endtask
    // The answer stands one cycle, so it is taken at the first falling edge
    task rd(input g, input [2:0] r, output ok, output [15:0] q);
        begin
            cmd(1'b0, g, r, 16'h0000);
            ok = i_rsp_valid;
            q = i_rsp_data;
        end
    endtask
    task cls;
        begin
            @(negedge i_sys_clk);
            o_clr = 1'b1;
            @(negedge i_sys_clk);
            o_clr = 1'b0;
        end
    endtask
endmodule

// ---- test/calibration_and_hw_status_groups_tb.sv ----
`timescale 1ns/1ps
module calibration_and_hw_status_groups_tb;
    reg         i_sys_clk = 1'b0;
    reg         i_rst = 1'b1;
    reg  [4:0]  cal = 5'h00;
    reg  [12:0] hw = 13'h0000;
    reg  [31:0] rnd;
    reg  [15:0] q, v;
    reg  [2:0]  r;
    reg         ok;
    integer     seed = 49696, n_mismatch = 0, checked = 0, cyc = 0, i, j;
    wire        rv, am, fm, cs, hs, cv, cw, cg, clr;
    wire [15:0] rdat, cd;
    wire [2:0]  cr;
    always #2.5 i_sys_clk = ~i_sys_clk;
    csr_status DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_txpwr_zero_fail(cal[4]),
        .i_voltmeter_cal_fail(cal[3]), .i_counter_cal_fail(cal[2]), .i_sampler_cal_fail(cal[1]),
        .i_spectrum_cal_fail(cal[0]), .i_acp_rbw_mismatch(hw[12]), .i_acp_too_wide(hw[11]),
        .i_audio_source_one_notch(hw[10]), .i_audio_source_two_volt(hw[9]),
        .i_fm_dev_too_large(hw[8]), .i_am_request(hw[7]), .i_fm_request(hw[6]),
        .i_audio_range_err(hw[5]), .i_rf_range_err(hw[4]), .i_rf_tune_err(hw[3]),
        .i_offset_mismatch(hw[2]), .i_gen_ampl_high(hw[1]), .i_ref_level_bad(hw[0]),
        .i_cmd_valid(cv), .i_cmd_write(cw), .i_cmd_group(cg), .i_cmd_reg(cr), .i_cmd_wdata(cd),
        .i_clear_status(clr), .o_rsp_valid(rv), .o_rsp_data(rdat), .o_am_enable(am),
        .o_fm_enable(fm), .o_cal_summary(cs), .o_hw_summary(hs));
    csr_host host (.i_sys_clk(i_sys_clk), .i_rsp_valid(rv), .i_rsp_data(rdat), .o_valid(cv),
        .o_write(cw), .o_group(cg), .o_reg(cr), .o_wdata(cd), .o_clr(clr));
    function [15:0] cond_exp(input g);
        cond_exp = g ? {4'h0, hw[12:8], hw[7] & hw[6], hw[5:0]} : {11'h000, cal};
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rchk(input g, input [2:0] rg, input [15:0] exp);
        begin
            host.rd(g, rg, ok, q);
            chk({15'h0000, ok}, 16'h0001);
            chk(q, exp);
        end
    endtask
    task results;
        begin
            $display("comparisons %0d mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Whole run needs under 20000 cycles
    always @(posedge i_sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            results;
        end
    end
    initial begin
        repeat (3) @(negedge i_sys_clk);
        i_rst = 1'b0;
        for (i = 0; i < 12; i = i + 1)
            rchk(i[0], i[3:1], (i[3:1] == 3'h1) ? 16'h7FFF : 16'h0000);
        for (i = 0; i < 40; i = i + 1) begin
            rnd = (i == 0) ? 32'hFFFFFFFF : $random(seed);
            cal = rnd[4:0];
            hw = rnd[20:8];
            host.cmd(1'b1, i[0], 3'h0, rnd[31:16]);
            rchk(1'b0, 3'h0, cond_exp(1'b0));
            rchk(1'b1, 3'h0, cond_exp(1'b1));
            chk({14'h0000, am, fm}, {14'h0000, hw[7] & ~hw[6], hw[6] & ~hw[7]});
        end
        for (i = 0; i < 12; i = i + 1) begin
            j = i % 6;
            rnd = $random(seed);
            r = (j < 2) ? 3'h1 : (j < 4) ? 3'h2 : 3'h4;
            v = (i < 6) ? rnd[15:0] : 16'h0000;
            host.cmd(1'b1, j[0], r, v);
            rchk(j[0], r, v);
        end
        cal = 5'h00;
        hw = 13'h0000;
        host.cmd(1'b1, 1'b0, 3'h1, 16'h0010);
        host.cmd(1'b1, 1'b0, 3'h2, 16'h0002);
        host.cmd(1'b1, 1'b0, 3'h4, 16'h0010);
        host.rd(1'b0, 3'h3, ok, q);
        cal = 5'h12;
        repeat (3) @(negedge i_sys_clk);
        chk({15'h0000, cs}, 16'h0001);
        rchk(1'b0, 3'h3, 16'h0010);
        rchk(1'b0, 3'h3, 16'h0000);
        chk({15'h0000, cs}, 16'h0000);
        cal = 5'h00;
        repeat (3) @(negedge i_sys_clk);
        rchk(1'b0, 3'h3, 16'h0002);
        cal = 5'h10;
        repeat (3) @(negedge i_sys_clk);
        host.cls;
        rchk(1'b0, 3'h3, 16'h0000);
        chk({15'h0000, cs}, 16'h0000);
        host.cmd(1'b1, 1'b1, 3'h1, 16'h0001);
        host.cmd(1'b1, 1'b1, 3'h4, 16'h0001);
        host.rd(1'b1, 3'h3, ok, q);
        hw = 13'h0001;
        repeat (3) @(negedge i_sys_clk);
        chk({15'h0000, hs}, 16'h0001);
        rchk(1'b1, 3'h3, 16'h0001);
        @(negedge i_sys_clk);
        chk({15'h0000, hs}, 16'h0000);
        results;
    end
endmodule
